/* core/hdc_map.svh */
/*
  Register offsets, field positions, reset values and timing counts
  of the host DRAM controller.
  Assumes inclusion by bare name from the controller module and the bench.
*/
`ifndef HDC_MAP_SVH
`define HDC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define HDC_OFS_CAS_PULSE 8'h50
`define HDC_OFS_REFRESH 8'h52
`define HDC_OFS_RAS_CAS 8'h53
`define HDC_OFS_WRITE_PUSH 8'h5B
`define HDC_OFS_BANK_BASE 8'h70
`define HDC_OFS_BANK_LAST 8'h77
`define HDC_OFS_BANK_HIGH 8'h79
`define HDC_OFS_EDO 8'h7C
`define HDC_OFS_BANK_TYPE 8'h7D
`define HDC_OFS_BANK_SIZE0 8'h7E
`define HDC_OFS_STATUS 8'h7F

// ****************************************
// Field positions
// ****************************************
`define HDC_RD_CAS_HI 7
`define HDC_RD_CAS_LO 6
`define HDC_WR_CAS_BIT 5
`define HDC_REF_RAS_BIT 0
`define HDC_CAS_PRE_BIT 7
`define HDC_RAS_CAS_BIT 2
`define HDC_RAS_PRE_BIT 1
`define HDC_PUSH_BIT 3
`define HDC_EDO_PULSE_BIT 1
`define HDC_EDO_PRE_BIT 0

// ****************************************
// Reset values
// ****************************************
`define HDC_RST_CAS_PULSE 8'h00
`define HDC_RST_REFRESH 8'h00
`define HDC_RST_RAS_CAS 8'h00
`define HDC_RST_WRITE_PUSH 8'h00
`define HDC_RST_BANK 8'h00
`define HDC_RST_EDO 8'h03

// ****************************************
// Timing counts in clocks
// ****************************************
`define HDC_T_RAS_CAS_FAST 4'h2
`define HDC_T_RAS_CAS_SLOW 4'h3
`define HDC_T_RAS_PRE_FAST 4'h3
`define HDC_T_RAS_PRE_SLOW 4'h4
`define HDC_T_REF_RAS_SHORT 4'h4
`define HDC_T_REF_RAS_LONG 4'h5
`define HDC_T_EDO_RETIRE 4'h2

`endif

/* core/hdc_pkg.sv */
/*
  Types of the host DRAM controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hdc_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    HDC_IDLE, HDC_PRE, HDC_RAS, HDC_CAS, HDC_CPRE, HDC_REF, HDC_DONE
  } hdc_state_t;

  // Host request to the controller
  typedef struct packed {
    logic valid;
    logic write;
    logic fill_wb;
    logic [31:0] addr;
  } hdc_req_t;

  // DRAM pins
  typedef struct packed {
    logic [11:0] mem_addr_mux;
    logic [7:0] ras_n;
    logic cas_n;
    logic we_n;
  } hdc_dram_t;
endpackage : hdc_pkg

/* core/hdc_ctrl.sv */
/*
  Host DRAM controller: bank decode, row/column multiplexing, posted
  write buffer with concurrent write-back, programmable RAS/CAS timing.
  Assumes a synchronous register port and a host that holds a request
  until it is acknowledged; refresh requests come from outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hdc_map.svh"

module hdc_ctrl import hdc_pkg::*; #(
  parameter int QW_DEPTH = 4,
  parameter int DATA_W = 64
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire hdc_req_t req_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wdata_valid_in,
  input wire logic refresh_req_in,
  output logic req_ack_out,
  output logic wdata_ready_out,
  output logic rdata_valid_out,
  output logic [DATA_W-1:0] dram_wdata_out,
  output logic dram_wdata_push_out,
  output logic hit_out,
  output hdc_dram_t dram_out
);

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    logic [7:0] cas_pulse;
    logic [7:0] refresh;
    logic [7:0] ras_cas;
    logic [7:0] write_push;
    logic [7:0][7:0] bank;
    logic [7:0] bank_high;
    logic [7:0] edo;
    logic [7:0] bank_type;
    logic [7:0][1:0] bank_size;
    logic [7:0] rdata;
    hdc_state_t st;
    logic [3:0] cnt;
    logic [1:0] beat;
    logic cur_write;
    logic cur_refresh;
    logic [2:0] cur_bank;
    logic [31:0] cur_addr;
    logic row_open;
    logic [2:0] open_bank;
    logic [11:0] open_row;
    logic buf_full;
    logic buf_fill;
    logic [1:0] buf_cnt;
    logic [31:0] buf_addr;
    logic [2:0] buf_bank;
    logic [QW_DEPTH-1:0][DATA_W-1:0] buf_data;
    logic read_pend;
    logic rvalid;
    logic push;
    logic [DATA_W-1:0] wdata;
    logic [3:0] lead;
    hdc_dram_t dram;
  } hdc_ctrl_state_t;

  hdc_ctrl_state_t s;
  hdc_ctrl_state_t next_s;

  // Size code per bank: 0 256K/512K, 1 1M/2M, 2 4M, 3 16M
  function automatic logic [11:0] row_of(input logic [31:0] a,
                                         input logic [1:0] sz);
    logic [11:0] r;
    r = {3'h0, a[20:15], a[14], a[13], a[12]};
    if (sz != 2'h0) begin
      r[0] = a[22];
      r[9] = a[21];
      r[10] = a[23];
    end else begin
      r[9] = a[21];
    end
    if (sz[1]) begin
      r[1] = a[24];
      r[11] = a[25];
    end
    if (sz == 2'h3) begin
      r[2] = a[26];
    end
    return r;
  endfunction : row_of

  function automatic logic [11:0] col_of(input logic [31:0] a,
                                         input logic [1:0] sz);
    logic [11:0] c;
    c = {3'h0, a[11:3]};
    if (sz != 2'h0) begin
      c[9] = a[12];
      c[10] = a[13];
    end
    return c;
  endfunction : col_of

  // Bank decode on the cumulative boundaries, nine bits each
  function automatic logic [2:0] bank_of(input logic [31:0] a,
      input logic [7:0][7:0] b, input logic [7:0] h);
    logic [2:0] n;
    logic [8:0] lo;
    logic [8:0] top;
    n = 3'h0;
    lo = 9'h000;
    for (int i = 0; i < 8; i++) begin
      top = {h[i], b[i]};
      if (a[29:21] >= lo && a[29:21] < top) begin
        n = 3'(i);
      end
      lo = top;
    end
    return n;
  endfunction : bank_of

  // ****************************************
  // Timing decode
  // ****************************************
  logic edo_bank;
  logic [3:0] t_rcd;
  logic [3:0] t_rp;
  logic [3:0] t_cas_rd;
  logic [3:0] t_cas_wr;
  logic [3:0] t_cpre;
  logic [3:0] t_ref;
  logic [2:0] req_bank;
  logic [11:0] req_row;

  // EDO banks pick up the 7Ch fields only when 7Ch bits 1:0 are both set, all other banks the 50h/53h ones
  always_comb begin
    edo_bank = s.bank_type[s.cur_bank] && s.edo[1:0] == 2'h3;
    t_rcd = s.ras_cas[`HDC_RAS_CAS_BIT] ? `HDC_T_RAS_CAS_SLOW
                                        : `HDC_T_RAS_CAS_FAST;
    t_rp = s.ras_cas[`HDC_RAS_PRE_BIT] ? `HDC_T_RAS_PRE_SLOW
                                       : `HDC_T_RAS_PRE_FAST;
    t_cas_rd = 4'(s.cas_pulse[`HDC_RD_CAS_HI:`HDC_RD_CAS_LO]) + 4'h1;
    t_cas_wr = s.cas_pulse[`HDC_WR_CAS_BIT] ? 4'h1 : 4'h2;
    t_cpre = s.ras_cas[`HDC_CAS_PRE_BIT] ? 4'h2 : 4'h1;
    t_ref = s.refresh[`HDC_REF_RAS_BIT] ? `HDC_T_REF_RAS_SHORT
                                        : `HDC_T_REF_RAS_LONG;
    if (edo_bank) begin
      t_cas_rd = s.edo[`HDC_EDO_PULSE_BIT] ? 4'h1 : 4'h2;
      t_cas_wr = t_cas_rd;
      t_cpre = s.edo[`HDC_EDO_PRE_BIT] ? 4'h1 : 4'h2;
    end
    req_bank = bank_of(req_in.addr, s.bank, s.bank_high);
    req_row = row_of(req_in.addr, s.bank_size[req_bank]);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.push = 1'b0;
    req_ack_out = 1'b0;
    wdata_ready_out = 1'b0;
    // Register writes
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `HDC_OFS_CAS_PULSE: next_s.cas_pulse = reg_wdata_in;
        `HDC_OFS_REFRESH: next_s.refresh = reg_wdata_in;
        `HDC_OFS_RAS_CAS: next_s.ras_cas = reg_wdata_in;
        `HDC_OFS_WRITE_PUSH: next_s.write_push = reg_wdata_in;
        `HDC_OFS_BANK_HIGH: next_s.bank_high = reg_wdata_in;
        `HDC_OFS_EDO: next_s.edo = reg_wdata_in;
        `HDC_OFS_BANK_TYPE: next_s.bank_type = reg_wdata_in;
        `HDC_OFS_BANK_SIZE0: next_s.bank_size[1:0] = reg_wdata_in[3:0];
        8'h7B: next_s.bank_size[7:2] = {reg_wdata_in[3:0], s.bank_size[5:2]};
        8'h7A: next_s.bank_size[5:2] = reg_wdata_in;
        default: begin
          if (reg_addr_in >= `HDC_OFS_BANK_BASE &&
              reg_addr_in <= `HDC_OFS_BANK_LAST) begin
            next_s.bank[reg_addr_in[2:0]] = reg_wdata_in;
          end
        end
      endcase
    end
    // Register reads: answer one cycle later, unmapped reads zero
    next_s.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `HDC_OFS_CAS_PULSE: next_s.rdata = s.cas_pulse;
        `HDC_OFS_REFRESH: next_s.rdata = s.refresh;
        `HDC_OFS_RAS_CAS: next_s.rdata = s.ras_cas;
        `HDC_OFS_WRITE_PUSH: next_s.rdata = s.write_push;
        `HDC_OFS_BANK_HIGH: next_s.rdata = s.bank_high;
        `HDC_OFS_EDO: next_s.rdata = s.edo;
        `HDC_OFS_BANK_TYPE: next_s.rdata = s.bank_type;
        `HDC_OFS_BANK_SIZE0: next_s.rdata = {4'h0, s.bank_size[1:0]};
        8'h7A: next_s.rdata = s.bank_size[5:2];
        8'h7B: next_s.rdata = {4'h0, s.bank_size[7:6]};
        `HDC_OFS_STATUS: next_s.rdata = {s.buf_full, s.row_open,
                                         s.open_bank, 3'(s.st)};
        default: begin
          if (reg_addr_in >= `HDC_OFS_BANK_BASE &&
              reg_addr_in <= `HDC_OFS_BANK_LAST) begin
            next_s.rdata = s.bank[reg_addr_in[2:0]];
          end
        end
      endcase
    end
    // Posted buffer fill: one quadword per beat at the host's pace
    if (s.buf_fill) begin
      wdata_ready_out = 1'b1;
      if (wdata_valid_in) begin
        next_s.buf_data[s.buf_cnt] = wdata_in;
        next_s.buf_cnt = s.buf_cnt + 2'h1;
        if (s.buf_cnt == 2'(QW_DEPTH - 1)) begin
          next_s.buf_fill = 1'b0;
          next_s.buf_full = 1'b1;
          next_s.buf_cnt = 2'h0;
        end
      end
    end
    if (s.cnt != 4'h0) begin
      next_s.cnt = s.cnt - 4'h1;
    end
    // DRAM sequencer
    unique case (s.st)
      HDC_IDLE: begin
        next_s.dram.cas_n = 1'b1;
        next_s.dram.we_n = 1'b1;
        if (refresh_req_in && !s.buf_fill) begin
          next_s.cur_refresh = 1'b1;
          next_s.row_open = 1'b0;
          next_s.dram.ras_n = 8'hFF;
          next_s.cnt = t_rp;
          next_s.st = HDC_PRE;
        end else if (s.buf_full && !s.read_pend && !s.buf_fill) begin
          next_s.cur_write = 1'b1;
          next_s.cur_refresh = 1'b0;
          next_s.cur_addr = s.buf_addr;
          next_s.cur_bank = s.buf_bank;
          next_s.st = HDC_PRE;
          next_s.cnt = t_rp;
        end else if (req_in.valid && (!s.buf_full || req_in.fill_wb)
                     && !s.buf_fill && (!s.read_pend || !req_in.write)) begin
          req_ack_out = 1'b1;
          if (req_in.write || req_in.fill_wb) begin
            next_s.buf_fill = 1'b1;
            next_s.buf_addr = req_in.addr;
            next_s.buf_bank = req_bank;
            next_s.buf_cnt = 2'h0;
          end
          if (!req_in.write) begin
            next_s.cur_write = 1'b0;
            next_s.cur_refresh = 1'b0;
            next_s.cur_addr = req_in.addr;
            next_s.cur_bank = req_bank;
            next_s.read_pend = 1'b1;
            // Leadoff class: page hit, row miss, page miss
            if (s.row_open && s.open_bank == req_bank &&
                s.open_row == req_row) begin
              next_s.lead = 4'h0;
              next_s.st = HDC_CAS;
            end else begin
              next_s.lead = s.row_open ? 4'h2 : 4'h1;
              next_s.st = s.row_open ? HDC_PRE : HDC_RAS;
              next_s.dram.ras_n = 8'hFF;
              next_s.cnt = s.row_open ? t_rp : 4'h0;
            end
          end
        end
      end
      HDC_PRE: begin
        next_s.dram.ras_n = 8'hFF;
        if (s.cnt <= 4'h1) begin
          next_s.row_open = 1'b0;
          next_s.st = s.cur_refresh ? HDC_REF : HDC_RAS;
          if (s.cur_refresh) begin
            next_s.dram.cas_n = 1'b0;
            next_s.cnt = t_ref;
          end
        end
      end
      HDC_RAS: begin
        if (s.dram.ras_n == 8'hFF) begin
          next_s.dram.mem_addr_mux = row_of(s.cur_addr,
                                            s.bank_size[s.cur_bank]);
          next_s.dram.ras_n = ~(8'h01 << s.cur_bank);
          next_s.open_bank = s.cur_bank;
          next_s.open_row = row_of(s.cur_addr, s.bank_size[s.cur_bank]);
          next_s.row_open = 1'b1;
          next_s.cnt = t_rcd;
        end else if (s.cnt <= 4'h1) begin
          next_s.st = HDC_CAS;
        end
      end
      HDC_CAS: begin
        if (s.dram.cas_n) begin
          next_s.dram.mem_addr_mux = col_of(s.cur_addr,
              s.bank_size[s.cur_bank]) | 12'(s.beat);
          if (s.cur_write && !s.push && s.write_push[`HDC_PUSH_BIT] &&
              s.cnt == 4'h0) begin
            next_s.push = 1'b1;
            next_s.wdata = s.buf_data[s.beat];
            next_s.cnt = 4'h1;
          end else if (s.cnt <= 4'h1) begin
            if (s.cur_write && !s.write_push[`HDC_PUSH_BIT]) begin
              next_s.push = 1'b1;
              next_s.wdata = s.buf_data[s.beat];
            end
            next_s.dram.cas_n = 1'b0;
            next_s.dram.we_n = ~s.cur_write;
            // Retire rate: EDO two clocks, three with the 5Bh push bit set; fast page follows CAS timing
            next_s.cnt = s.cur_write ? (edo_bank ? `HDC_T_EDO_RETIRE - 4'h1
                                                 : t_cas_wr)
                                     : t_cas_rd;
          end
        end else if (s.cnt <= 4'h1) begin
          next_s.dram.cas_n = 1'b1;
          next_s.rvalid = ~s.cur_write;
          next_s.cnt = t_cpre;
          next_s.st = HDC_CPRE;
          // EDO 1T precharge is the column setup cycle itself; skipping
          // the precharge state is what makes the two-clock beat
          if (edo_bank) begin
            next_s.beat = s.beat + 2'h1;
            next_s.st = (s.beat == 2'(QW_DEPTH - 1)) ? HDC_DONE : HDC_CAS;
            next_s.cnt = 4'h0;
          end
        end
      end
      HDC_CPRE: begin
        if (s.cnt <= 4'h1) begin
          next_s.beat = s.beat + 2'h1;
          next_s.st = (s.beat == 2'(QW_DEPTH - 1)) ? HDC_DONE : HDC_CAS;
          next_s.cnt = 4'h0;
        end
      end
      HDC_REF: begin
        // Row strobes fall one clock after entry, so run down to zero
        if (s.cnt == 4'h0) begin
          next_s.dram.ras_n = 8'hFF;
          next_s.dram.cas_n = 1'b1;
          next_s.st = HDC_DONE;
        end else begin
          next_s.dram.ras_n = 8'h00;
        end
      end
      HDC_DONE: begin
        next_s.beat = 2'h0;
        next_s.dram.we_n = 1'b1;
        if (s.cur_write) begin
          next_s.buf_full = 1'b0;
        end
        if (!s.cur_write && !s.cur_refresh) begin
          next_s.read_pend = 1'b0;
        end
        next_s.cur_refresh = 1'b0;
        next_s.st = HDC_IDLE;
      end
      default: next_s.st = HDC_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.cas_pulse <= `HDC_RST_CAS_PULSE;
      s.refresh <= `HDC_RST_REFRESH;
      s.ras_cas <= `HDC_RST_RAS_CAS;
      s.write_push <= `HDC_RST_WRITE_PUSH;
      s.edo <= `HDC_RST_EDO;
      s.st <= HDC_IDLE;
      s.dram.ras_n <= 8'hFF;
      s.dram.cas_n <= 1'b1;
      s.dram.we_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state record
  assign reg_rdata_out = s.rdata;
  assign rdata_valid_out = s.rvalid;
  assign dram_wdata_out = s.wdata;
  assign dram_wdata_push_out = s.push;
  assign hit_out = (s.lead == 4'h0) && s.read_pend;
  assign dram_out = s.dram;

endmodule : hdc_ctrl
`default_nettype wire

/* test/hdc_ctrl_properties.sv */
/*
  Port checks of the host DRAM controller.
  Assumes binding onto hdc_ctrl and the hdc_pkg types.
*/
`timescale 1ns/1ns
`default_nettype none
module hdc_ctrl_properties import hdc_pkg::*; #(
  parameter int QW_DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire hdc_req_t req_in,
  input wire logic req_ack_out,
  input wire logic wdata_ready_out,
  input wire logic rdata_valid_out,
  input wire logic dram_wdata_push_out,
  input wire hdc_dram_t dram_out
);
  // ****************************************
  // Named steps of a posted write
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_write_taken;
    req_ack_out && req_in.write;
  endsequence
  sequence s_beats_open;
    wdata_ready_out;
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  // Reset itself is the cause here, so nothing disables it
  reset_pins_a: assert property (disable iff (1'b0)
    rst_in |=> dram_out.ras_n == 8'hFF && dram_out.cas_n
      && dram_out.we_n && !dram_wdata_push_out)
    else $error("pins not idle after reset");
  ack_pulse_a: assert property (
    req_ack_out |-> req_in.valid ##1 !req_ack_out)
    else $error("ack without request or longer than a cycle");
  rdata_idle_a: assert property (
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data without a read strobe");
  read_gap_a: assert property (
    rdata_valid_out |=> !rdata_valid_out)
    else $error("read beats closer than two clocks");
  retire_gap_a: assert property (
    dram_wdata_push_out |=> !dram_wdata_push_out)
    else $error("retire pushes closer than two clocks");
  retire_stall_a: assert property (
    dram_wdata_push_out |-> !req_ack_out)
    else $error("request taken while buffer retires");
  fill_block_a: assert property (
    wdata_ready_out |-> !req_ack_out)
    else $error("request taken while buffer fills");
  fill_apart_a: assert property (
    dram_wdata_push_out |-> !wdata_ready_out)
    else $error("buffer fills and retires at once");
  beats_open_a: assert property (
    s_write_taken |=> s_beats_open)
    else $error("write taken but buffer not open");
endmodule : hdc_ctrl_properties

bind hdc_ctrl hdc_ctrl_properties #(.QW_DEPTH(QW_DEPTH))
  i_hdc_ctrl_properties (.clk_in(clk_in), .rst_in(rst_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .req_in(req_in), .req_ack_out(req_ack_out),
  .wdata_ready_out(wdata_ready_out), .rdata_valid_out(rdata_valid_out),
  .dram_wdata_push_out(dram_wdata_push_out), .dram_out(dram_out));
`default_nettype wire

/* test/hdc_simm_model.sv */
/*
  SIMM bank model: records bank, row, column and write strobes.
  Assumes registered DRAM pins from the controller.
*/
`timescale 1ns/1ns
`default_nettype none
module hdc_simm_model import hdc_pkg::*; (
  input wire logic clk_in,
  input wire hdc_dram_t dram_in,
  output logic [2:0] bank_out,
  output logic [11:0] row_out,
  output logic [11:0] col_out,
  output logic [15:0] writes_out
);
  logic ras_idle = 1'b1;
  logic cas_high = 1'b1;
  logic col_due = 1'b0;
  initial writes_out = 16'h0000;

  // ****************************************
  // Strobe capture
  // ****************************************
  // Row at the row strobe, column at the first CAS after it; any bank
  // may be fast page or EDO, so no part timing is imposed here
  always @(posedge clk_in) begin
    if (ras_idle && dram_in.ras_n != 8'hFF) begin
      for (int b = 0; b < 8; b++)
        if (!dram_in.ras_n[b]) bank_out <= 3'(b);
      row_out <= dram_in.mem_addr_mux;
      col_due <= 1'b1;
    end
    if (cas_high && !dram_in.cas_n) begin
      if (col_due) col_out <= dram_in.mem_addr_mux;
      col_due <= 1'b0;
      if (!dram_in.we_n) writes_out <= writes_out + 16'h0001;
    end
    ras_idle <= dram_in.ras_n == 8'hFF;
    cas_high <= dram_in.cas_n;
  end
endmodule : hdc_simm_model
`default_nettype wire

/* test/hdc_ctrl_bench.sv */
/*
  Self-checking bench of the host DRAM controller.
  Assumes the controller, its package and map header, the SIMM model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hdc_map.svh"
module hdc_ctrl_bench import hdc_pkg::*; ;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  hdc_req_t req_in = '0;
  logic [63:0] wdata_in = 64'h0;
  logic wdata_valid_in = 1'b0;
  logic refresh_req_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic req_ack_out, wdata_ready_out, rdata_valid_out, hit_out;
  logic dram_wdata_push_out;
  logic [63:0] dram_wdata_out;
  hdc_dram_t dram_out;
  logic [2:0] bank;
  logic [11:0] row, col;
  logic [15:0] writes;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int ack_cyc, rv_c[$], push_c[$];
  logic [63:0] push_q[$];
  logic hit_q[$];

  hdc_ctrl i_hdc_ctrl (.clk_in(clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .req_in(req_in), .wdata_in(wdata_in),
    .wdata_valid_in(wdata_valid_in), .refresh_req_in(refresh_req_in),
    .req_ack_out(req_ack_out), .wdata_ready_out(wdata_ready_out),
    .rdata_valid_out(rdata_valid_out), .dram_wdata_out(dram_wdata_out),
    .dram_wdata_push_out(dram_wdata_push_out), .hit_out(hit_out),
    .dram_out(dram_out));
  hdc_simm_model i_hdc_simm_model (.clk_in(clk_in), .dram_in(dram_out),
    .bank_out(bank), .row_out(row), .col_out(col), .writes_out(writes));

  // ****************************************
  // Clock and monitors
  // ****************************************
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  // Stamps taken mid-cycle so that edge updates have landed
  always @(negedge clk_in) begin
    if (rdata_valid_out === 1'b1) begin
      rv_c.push_back(cyc);
      hit_q.push_back(hit_out);
    end
    if (dram_wdata_push_out === 1'b1) begin
      push_c.push_back(cyc);
      push_q.push_back(dram_wdata_out);
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic give_up();
    check(64'h0, 64'h1);
    print_verdict();
  endtask : give_up

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 check(64'(reg_rdata_out), 64'(exp));
  endtask : reg_rd

  // Request held until the acknowledge is seen
  task automatic host_req(input logic [31:0] a, input logic wr, fl);
    int k;
    @(posedge clk_in);
    req_in <= '{1'b1, wr, fl, a};
    for (k = 0; k < 300 && req_ack_out !== 1'b1; k++) @(negedge clk_in);
    if (k == 300) give_up();
    ack_cyc = cyc;
    @(posedge clk_in);
    req_in <= '0;
  endtask : host_req

  task automatic send_beats(input logic [63:0] base);
    int k;
    for (int i = 0; i < 4; i++) begin
      wdata_in <= base + 64'(i);
      wdata_valid_in <= 1'b1;
      k = 0;
      do begin
        @(negedge clk_in);
        k++;
      end while (wdata_ready_out !== 1'b1 && k < 300);
      if (k == 300) give_up();
      @(posedge clk_in);
    end
    wdata_valid_in <= 1'b0;
  endtask : send_beats

  task automatic wait_beats(input int n, input bit pushes);
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk_in);
      #1;
      if ((pushes ? push_c.size() : rv_c.size()) >= n) break;
    end
    if (k == 300) give_up();
  endtask : wait_beats

  task automatic do_read(input logic [31:0] a, input logic fl,
                         output int lead, output int gap, output logic h);
    rv_c.delete();
    hit_q.delete();
    host_req(a, 1'b0, fl);
    if (fl) send_beats(64'hC0DE_0000_0000_0000);
    wait_beats(4, 1'b0);
    lead = rv_c[0] - ack_cyc;
    gap = rv_c[1] - rv_c[0];
    h = hit_q[0];
  endtask : do_read

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_registers();
    logic [7:0] ofs [5] = '{8'h50, 8'h52, 8'h53, 8'h5B, 8'h7C};
    logic [7:0] rv [5] = '{`HDC_RST_CAS_PULSE, `HDC_RST_REFRESH,
      `HDC_RST_RAS_CAS, `HDC_RST_WRITE_PUSH, `HDC_RST_EDO};
    for (int i = 0; i < 5; i++) begin
      reg_rd(ofs[i], rv[i]);
      reg_wr(ofs[i], 8'hA5);
      reg_rd(ofs[i], 8'hA5);
      reg_wr(ofs[i], rv[i]);
    end
    for (int i = 0; i < 9; i++) begin
      reg_rd(i < 8 ? 8'h70 + 8'(i) : 8'h79, `HDC_RST_BANK);
      reg_wr(i < 8 ? 8'h70 + 8'(i) : 8'h79, 8'h5A);
      reg_rd(i < 8 ? 8'h70 + 8'(i) : 8'h79, 8'h5A);
    end
    reg_wr(8'h60, 8'hFF);
    reg_rd(8'h60, 8'h00);
  endtask : t_registers

  // Banks 1 and 3 hold 8 MB each, bank 5 stays empty, both are EDO
  task automatic setup_banks();
    logic [7:0] bnd [9] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08,
      8'h08, 8'h08, 8'h00};
    for (int i = 0; i < 9; i++)
      reg_wr(i < 8 ? 8'h70 + 8'(i) : 8'h79, bnd[i]);
    reg_wr(8'h7E, 8'h04);
    reg_wr(8'h7A, 8'h04);
    reg_wr(8'h7D, 8'h0A);
  endtask : setup_banks

  task automatic t_read_pages();
    logic [31:0] a = 32'h00C5_A7E0;
    int l_row, l_hit, l_page, g;
    logic h;
    do_read(a, 1'b0, l_row, g, h);
    check(64'(bank), 64'h3);
    check(64'(col[9:0]), 64'({a[12], a[11:3]}));
    check(64'({row[8:3], row[0]}), 64'({a[20:15], a[22]}));
    check(64'(g), 64'h2);
    check(64'(h), 64'h0);
    do_read(a + 32'h20, 1'b0, l_hit, g, h);
    check(64'(h), 64'h1);
    check(64'(l_hit < l_row), 64'h1);
    do_read(a ^ 32'h8000, 1'b0, l_page, g, h);
    check(64'(l_page > l_row), 64'h1);
  endtask : t_read_pages

  // Fast page, slow CAS precharge, then EDO with its fast bits off
  task automatic t_rates();
    logic [7:0] typ [3] = '{8'h02, 8'h02, 8'h0A};
    logic [7:0] pre [3] = '{8'h00, 8'h80, 8'h00};
    logic [7:0] edo [3] = '{8'h03, 8'h03, 8'h00};
    logic [63:0] gap [3] = '{64'h3, 64'h4, 64'h3};
    int l, g;
    logic h;
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'h7D, typ[i]);
      reg_wr(8'h53, pre[i]);
      reg_wr(8'h7C, edo[i]);
      do_read(32'h00C0_0000, 1'b0, l, g, h);
      check(64'(g), gap[i]);
    end
    reg_wr(8'h7D, 8'h0A);
    reg_wr(8'h53, 8'h00);
    reg_wr(8'h7C, 8'h03);
  endtask : t_rates

  // A read right behind a posted write must wait for the retire
  task automatic t_write_post();
    logic [15:0] w0 = writes;
    int l, g;
    logic h;
    push_q.delete();
    push_c.delete();
    host_req(32'h0000_0040, 1'b1, 1'b0);
    send_beats(64'h5A5A_0000_0000_0000);
    do_read(32'h00C5_A7E0, 1'b0, l, g, h);
    wait_beats(4, 1'b1);
    for (int i = 0; i < 4; i++)
      check(push_q[i], 64'h5A5A_0000_0000_0000 + 64'(i));
    for (int i = 0; i < 3; i++)
      check(64'(push_c[i + 1] - push_c[i]), 64'h2);
    check(64'(ack_cyc > push_c[3]), 64'h1);
    check(64'(writes - w0), 64'h4);
  endtask : t_write_post

  // Victim data is buffered, read beats come before any retire
  task automatic t_fill_wb();
    int l, g;
    logic h;
    push_q.delete();
    push_c.delete();
    do_read(32'h0000_1000, 1'b1, l, g, h);
    wait_beats(4, 1'b1);
    check(64'(push_c[0] > rv_c[3]), 64'h1);
    check(push_q[3], 64'hC0DE_0000_0000_0003);
  endtask : t_fill_wb

  // CAS-before-RAS refresh: row strobes low for the programmed time
  task automatic t_refresh();
    int k, n;
    @(posedge clk_in);
    refresh_req_in <= 1'b1;
    for (k = 0; k < 300 && dram_out.ras_n !== 8'h00; k++) @(negedge clk_in);
    if (k == 300) give_up();
    check(64'(dram_out.cas_n), 64'h0);
    for (n = 0; n < 20 && dram_out.ras_n === 8'h00; n++) begin
      @(posedge clk_in);
      refresh_req_in <= 1'b0;
      @(negedge clk_in);
    end
    check(64'(n), 64'(`HDC_T_REF_RAS_LONG));
  endtask : t_refresh

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_registers();
    setup_banks();
    t_read_pages();
    t_rates();
    t_write_post();
    t_fill_wb();
    t_refresh();
    print_verdict();
  end
endmodule : hdc_ctrl_bench
`default_nettype wire
